// >>> logic/sdm_supply_drop_monitor_control.sv
/*
  Supply-drop detector control with early-warning monitor and register port.
  Assumes analog comparator outputs are asynchronous, sleep and debug
  status and the unlock key pulse come from core-clock logic.
*/
// Function
// - Load all detector settings from fuses at reset
// - Threshold and run mode ignore software writes
// - Enable bit turns on the warning interrupt
// - Monitor stays off while detector disabled
// - Sampled mode samples the monitor too
// - Enabling with both-crossings sets the flag
// - Flag set on crossing in chosen direction
// - Request while enable and flag both set
// - No warning request while CPU debug halted
// - Sleep uses sleep mode, wake uses run
// - Sleep field unchanged without valid unlock
// - Rate bit: 0 is 128 Hz, 1 is 32 Hz
// - Run mode decode, mode 3 holds wake-up
// - Sleep mode decode, value 3 reserved
// - Rate, run and sleep fields from fuses
// - System reset when supply below threshold
// - Sampled mode powers detector only briefly
// - Warning level decode, zero means off
// - Trigger config decode, other values reserved
// - Flag sets only while detector enabled
// - Status shows below-warning while enabled
`timescale 1ns/1ps
module sdm_supply_drop_monitor_control
  import sdm_pkg::*;
#(
  parameter int SAMPLE_FAST = SAMPLE_FAST_CYC,
  parameter int SAMPLE_SLOW = SAMPLE_SLOW_CYC
)(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [2:0] fuse_threshold_in,
  input  wire logic [1:0] fuse_run_mode_in,
  input  wire logic [1:0] fuse_sleep_mode_in,
  input  wire logic       fuse_rate_in,
  input  wire logic       unlock_key_in,
  input  wire logic       deep_sleep_in,
  input  wire logic       debug_halt_in,
  input  wire logic       supply_below_bod_in,
  input  wire logic       supply_below_warn_in,
  input  wire logic       detector_ready_in,
  output logic            detector_power_out,
  output logic      [2:0] threshold_select_out,
  output logic      [1:0] warning_level_select_out,
  output logic            sys_reset_req_out,
  output logic            warning_irq_out,
  output logic            continuous_hold_wakeup_out
);
  localparam int CNT_W = $clog2(SAMPLE_SLOW + 1);

  logic [1:0]       rst_sync_ff;
  logic             rst_n;
  logic             load_pending_ff;
  logic [2:0]       thresh_ff;
  logic [1:0]       run_mode_ff;
  logic [1:0]       sleep_mode_ff;
  logic             rate_ff;
  logic [1:0]       warn_lvl_ff;
  logic [1:0]       irq_cfg_ff;
  logic             irq_en_ff;
  logic             flag_ff;
  logic             warn_below_ff;
  logic             bod_below_ff;
  logic [2:0]       unlock_cnt_ff;
  logic [2:0]       s1_ff;
  logic [2:0]       s2_ff;
  logic [2:0]       s3_ff;
  logic [2:0]       filt_ff;
  logic [CNT_W-1:0] smp_cnt_ff;
  logic             sleep_prev_ff;
  logic             hold_ff;
  logic [7:0]       rdata_ff;
  sdm_mode_t        cur_mode;
  logic             det_enabled;
  logic             sample_eval;
  logic             warn_active;
  logic             en_rise;
  logic             cross_fall;
  logic             cross_rise;
  logic             set_flag;
  logic             wr_mode;
  logic             wr_flags;
  logic             wr_irq;
  logic [CNT_W-1:0] period_last;

  // Reset release through two flops
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Analog inputs: three flops, accept when second and third agree
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff   <= 3'h0;
      s2_ff   <= 3'h0;
      s3_ff   <= 3'h0;
      filt_ff <= 3'h0;
    end
    else
    begin
      s1_ff <= {detector_ready_in, supply_below_warn_in,
                supply_below_bod_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 3; i++)
        if (s2_ff[i] == s3_ff[i])
          filt_ff[i] <= s3_ff[i];
    end
  end

  assign wr_mode  = reg_wr_in && (reg_addr_in == ADDR_MODE_CTRL);
  assign wr_irq   = reg_wr_in && (reg_addr_in == ADDR_IRQ_CTRL);
  assign wr_flags = reg_wr_in && (reg_addr_in == ADDR_IRQ_FLAGS);

  // Fuse capture on the first edge after reset release
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      load_pending_ff <= 1'b1;
    else
      load_pending_ff <= 1'b0;
  end

  // Fuse-fixed fields; no write path exists
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thresh_ff   <= 3'h0;
      run_mode_ff <= 2'h0;
      rate_ff     <= 1'b0;
    end
    else if (load_pending_ff)
    begin
      thresh_ff   <= fuse_threshold_in;
      run_mode_ff <= fuse_run_mode_in;
      rate_ff     <= fuse_rate_in;
    end
  end

  // Unlock window opened by the key pulse
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      unlock_cnt_ff <= 3'h0;
    else if (unlock_key_in)
      unlock_cnt_ff <= 3'(UNLOCK_WINDOW_CYC);
    else if (wr_mode)
      unlock_cnt_ff <= 3'h0;
    else if (unlock_cnt_ff != 3'h0)
      unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
  end

  // Protected sleep field; reserved code 3 is not accepted from writes, but fuses can load it
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      sleep_mode_ff <= 2'h0;
    else if (load_pending_ff)
      sleep_mode_ff <= fuse_sleep_mode_in;
    else if (wr_mode && (unlock_cnt_ff != 3'h0) &&
             (reg_wdata_in[SLEEP_LSB +: 2] != MODE_CONT_WAIT))
      sleep_mode_ff <= reg_wdata_in[SLEEP_LSB +: 2];
  end

  // Warning configuration registers
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      warn_lvl_ff <= RST_WARN_LVL;
      irq_cfg_ff  <= RST_IRQ_CFG;
      irq_en_ff   <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == ADDR_WARN_LVL))
        warn_lvl_ff <= reg_wdata_in[1:0];
      if (wr_irq)
      begin
        irq_cfg_ff <= reg_wdata_in[IRQ_CFG_LSB +: 2];
        irq_en_ff  <= reg_wdata_in[IRQ_EN_BIT];
      end
    end
  end

  // Active mode follows sleep state
  assign cur_mode    = deep_sleep_in ? sdm_decode(sleep_mode_ff)
                                     : sdm_decode(run_mode_ff);
  assign det_enabled = (cur_mode != SDM_OFF);
  assign period_last = rate_ff ? CNT_W'(SAMPLE_SLOW - 1)
                               : CNT_W'(SAMPLE_FAST - 1);

  // Sample period counter, idle outside sampled mode
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      smp_cnt_ff <= '0;
    else if ((cur_mode != SDM_SAMP) || (smp_cnt_ff >= period_last))
      smp_cnt_ff <= '0;
    else
      smp_cnt_ff <= smp_cnt_ff + CNT_W'(1);
  end

  // Detector is powered always in continuous mode, for a short window at each period start in sampled mode
  assign detector_power_out = (cur_mode == SDM_CONT) ||
    ((cur_mode == SDM_SAMP) &&
     (smp_cnt_ff < CNT_W'(SAMPLE_ON_CYC)));
  assign sample_eval = (cur_mode == SDM_CONT) ||
    ((cur_mode == SDM_SAMP) &&
     (smp_cnt_ff == CNT_W'(SAMPLE_ON_CYC - 1)));

  // Brown-out result, held between samples
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      bod_below_ff <= 1'b0;
    else if (!det_enabled)
      bod_below_ff <= 1'b0;
    else if (sample_eval)
      bod_below_ff <= filt_ff[0];
  end
  assign sys_reset_req_out = det_enabled && bod_below_ff;

  assign warn_active = det_enabled && irq_en_ff &&
                       (warn_lvl_ff != LVL_OFF);
  // Previous state reloads on enable, so only the both setting flags then
  assign en_rise    = wr_irq && reg_wdata_in[IRQ_EN_BIT] && !irq_en_ff;
  assign cross_fall = sample_eval && filt_ff[1] && !warn_below_ff;
  assign cross_rise = sample_eval && !filt_ff[1] && warn_below_ff;

  always_comb
  begin
    set_flag = 1'b0;
    if (en_rise && det_enabled &&
        (reg_wdata_in[IRQ_CFG_LSB +: 2] == CFG_BOTH))
      set_flag = 1'b1;
    else if (warn_active)
    begin
      unique case (irq_cfg_ff)
        CFG_FALL: set_flag = cross_fall;
        CFG_RISE: set_flag = cross_rise;
        CFG_BOTH: set_flag = cross_fall || cross_rise;
        default:  set_flag = 1'b0;
      endcase
    end
  end

  // Below-warning state tracks the monitor level
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      warn_below_ff <= 1'b0;
    else if (!det_enabled || (warn_lvl_ff == LVL_OFF))
      warn_below_ff <= 1'b0;
    else if (sample_eval || en_rise)
      warn_below_ff <= filt_ff[1];
  end

  // Sticky flag; a set in the clear cycle wins
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else if (set_flag && det_enabled)
      flag_ff <= 1'b1;
    else if (wr_flags && reg_wdata_in[FLAG_BIT])
      flag_ff <= 1'b0;
  end

  assign warning_irq_out = irq_en_ff && flag_ff &&
                           !debug_halt_in;

  // Wake-up hold for continuous-with-wait run mode
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_prev_ff <= 1'b0;
      hold_ff       <= 1'b0;
    end
    else
    begin
      sleep_prev_ff <= deep_sleep_in;
      if (sleep_prev_ff && !deep_sleep_in &&
          (run_mode_ff == MODE_CONT_WAIT))
        hold_ff <= 1'b1;
      else if (filt_ff[2])
        hold_ff <= 1'b0;
    end
  end
  assign continuous_hold_wakeup_out = hold_ff;

  assign threshold_select_out     = thresh_ff;
  assign warning_level_select_out = warn_lvl_ff;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (!reg_rd_in)
      rdata_ff <= 8'h00;
    else
    begin
      unique case (reg_addr_in)
        ADDR_MODE_CTRL: rdata_ff <= {3'h0, rate_ff, run_mode_ff,
                                     sleep_mode_ff};
        ADDR_THRESH:    rdata_ff <= {5'h00, thresh_ff};
        ADDR_WARN_LVL:  rdata_ff <= {6'h00, warn_lvl_ff};
        ADDR_IRQ_CTRL:  rdata_ff <= {5'h00, irq_cfg_ff, irq_en_ff};
        ADDR_IRQ_FLAGS: rdata_ff <= {7'h00, flag_ff};
        ADDR_STATUS:    rdata_ff <= {7'h00,
                                     warn_below_ff && det_enabled};
        default:        rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_out = rdata_ff;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_fuse_capture: assert property (
    load_pending_ff && rst_n |=> (thresh_ff == $past(fuse_threshold_in)) &&
      (run_mode_ff == $past(fuse_run_mode_in)))
    else $error("fuse settings not captured");
  a_fixed_fields: assert property (
    !load_pending_ff |=> $stable(thresh_ff) && $stable(run_mode_ff) &&
      $stable(rate_ff))
    else $error("fuse-fixed field changed");
  a_sleep_locked: assert property (
    wr_mode && (unlock_cnt_ff == 3'h0) && !load_pending_ff
      |=> $stable(sleep_mode_ff))
    else $error("sleep field changed without unlock");
  a_unlock_expiry: assert property (
    unlock_key_in ##1 (!unlock_key_in && !wr_mode) [*4]
      |=> unlock_cnt_ff == 3'h0)
    else $error("unlock window too long");
  a_monitor_off: assert property (
    !det_enabled |=> !flag_ff || $past(flag_ff))
    else $error("flag set while detector off");
  a_both_on_enable: assert property (
    en_rise && det_enabled &&
      (reg_wdata_in[IRQ_CFG_LSB +: 2] == CFG_BOTH) |=> flag_ff)
    else $error("both-crossings enable did not set flag");
  a_flag_clear: assert property (
    wr_flags && reg_wdata_in[FLAG_BIT] && !set_flag |=> !flag_ff)
    else $error("flag not cleared");
  a_irq_hold: assert property (
    warning_irq_out && !wr_flags && !wr_irq && !debug_halt_in
      |=> warning_irq_out || debug_halt_in)
    else $error("request dropped before flag clear");
  a_debug_mask: assert property (
    debug_halt_in |-> !warning_irq_out)
    else $error("warning request in debug halt");
  a_sampled_hold: assert property (
    (cur_mode == SDM_SAMP) && !sample_eval && !en_rise &&
      $stable(cur_mode) && (warn_lvl_ff != LVL_OFF)
      |=> $stable(warn_below_ff))
    else $error("monitor evaluated between samples");
  a_power_window: assert property (
    (cur_mode == SDM_SAMP) && $past(cur_mode == SDM_SAMP) &&
      $fell(detector_power_out)
      |-> smp_cnt_ff == CNT_W'(SAMPLE_ON_CYC))
    else $error("sampled power window wrong length");
  a_reset_req: assert property (
    det_enabled && sample_eval && filt_ff[0] |=>
      sys_reset_req_out || !det_enabled)
    else $error("no system reset below threshold");

  c_sleep_entry: cover property ($rose(deep_sleep_in) && det_enabled);
  c_flag_set:    cover property ($rose(flag_ff));
  c_reset_req:   cover property ($rose(sys_reset_req_out));
  c_wake_hold:   cover property ($fell(hold_ff));
endmodule

// >>> logic/sdm_pkg.sv
/*
  Constants, types and decode helpers for the supply-drop monitor control.
  Assumes a single 250 MHz core clock and an 8-bit register port.
*/
package sdm_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_THRESH     = 8'h01;
  localparam logic [7:0] ADDR_WARN_LVL   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h09;
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h0a;
  localparam logic [7:0] ADDR_STATUS     = 8'h0b;
  // Field positions
  localparam int SLEEP_LSB    = 0;
  localparam int RUN_LSB      = 2;
  localparam int RATE_BIT     = 4;
  localparam int IRQ_EN_BIT   = 0;
  localparam int IRQ_CFG_LSB  = 1;
  localparam int FLAG_BIT     = 0;
  localparam int STATUS_BIT   = 0;
  // Reset values
  localparam logic [1:0] RST_WARN_LVL = 2'h0;
  localparam logic [1:0] RST_IRQ_CFG  = 2'h0;
  // Mode, level and trigger codes
  localparam logic [1:0] MODE_DISABLED  = 2'h0;
  localparam logic [1:0] MODE_CONT      = 2'h1;
  localparam logic [1:0] MODE_SAMPLED   = 2'h2;
  localparam logic [1:0] MODE_CONT_WAIT = 2'h3;
  localparam logic [1:0] LVL_OFF        = 2'h0;
  localparam logic [1:0] CFG_FALL       = 2'h0;
  localparam logic [1:0] CFG_RISE       = 2'h1;
  localparam logic [1:0] CFG_BOTH       = 2'h2;
  // Timing
  localparam int CLK_HZ             = 250_000_000;
  localparam int CLK_PERIOD_NS      = 4;
  localparam int RATE_FAST_HZ       = 128;
  localparam int RATE_SLOW_HZ       = 32;
  localparam int SAMPLE_FAST_CYC    = CLK_HZ / RATE_FAST_HZ;
  localparam int SAMPLE_SLOW_CYC    = CLK_HZ / RATE_SLOW_HZ;
  localparam int SAMPLE_ON_NS       = 1000;
  localparam int SAMPLE_ON_CYC      =
    (SAMPLE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_WINDOW_INSTR = 4;
  localparam int UNLOCK_WINDOW_CYC   = UNLOCK_WINDOW_INSTR;

  typedef enum logic [1:0] {SDM_OFF, SDM_CONT, SDM_SAMP} sdm_mode_t;

  function automatic sdm_mode_t sdm_decode(input logic [1:0] code);
    sdm_mode_t m;
    m = SDM_OFF;
    unique case (code)
      MODE_DISABLED:  m = SDM_OFF;
      MODE_CONT:      m = SDM_CONT;
      MODE_SAMPLED:   m = SDM_SAMP;
      MODE_CONT_WAIT: m = SDM_CONT;
    endcase
    return m;
  endfunction
endpackage

// >>> testbench/sdm_supply_model.sv
/*
  Behavioural analog front end: comparators and detector warm-up.
  Assumes the bench commands the supply level on the two cmd inputs.
*/
`timescale 1ns/1ps
module sdm_supply_model (
  input  wire logic core_clk_in,
  input  wire logic power_in,
  input  wire logic below_bod_cmd_in,
  input  wire logic below_warn_cmd_in,
  output logic      below_bod_out,
  output logic      below_warn_out,
  output logic      ready_out
);
  logic [1:0] warm_ff = 2'h0;
  logic       junk_ff = 1'b0;

  // Unpowered comparators give junk, never the last level
  always @(posedge core_clk_in)
  begin
    warm_ff <= power_in ? {warm_ff[0], 1'b1} : 2'h0;
    junk_ff <= ~junk_ff;
  end

  assign ready_out      = warm_ff[1];
  assign below_bod_out  = ready_out ? below_bod_cmd_in : junk_ff;
  assign below_warn_out = ready_out ? below_warn_cmd_in : ~junk_ff;
endmodule

// >>> testbench/test_sdm_supply_drop_monitor_control.sv
/*
  Self-checking bench for the supply-drop monitor control.
  Assumes sdm_pkg and the supply model are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); fails++; end end
module test_sdm_supply_drop_monitor_control
  import sdm_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       key = 1'b0;
  logic       sleep = 1'b0;
  logic       dbg = 1'b0;
  logic       bod_cmd = 1'b0;
  logic       warn_cmd = 1'b0;
  logic [2:0] f_thr = 3'h5;
  logic [1:0] f_run = 2'h1;
  logic [1:0] f_slp = 2'h2;
  logic       f_rate = 1'b1;
  logic [7:0] rdata;
  logic       bod_c;
  logic       warn_c;
  logic       rdy;
  logic       pwr;
  logic       sysrst;
  logic       irq;
  logic [2:0] thr_o;
  logic [1:0] lvl_o;
  logic       hold;
  int         fails = 0;
  int         checks_done = 0;
  int         n;
  localparam int FAST_SIM = 600;
  localparam int SLOW_SIM = 2000;

  always #2 clk = ~clk;

  sdm_supply_drop_monitor_control #(
    .SAMPLE_FAST (FAST_SIM),
    .SAMPLE_SLOW (SLOW_SIM)
  ) sdm_supply_drop_monitor_control_i (
    .core_clk_in                (clk),
    .reset_n_in                 (rst_n),
    .reg_addr_in                (addr),
    .reg_wdata_in               (wdata),
    .reg_wr_in                  (wr),
    .reg_rd_in                  (rd),
    .reg_rdata_out              (rdata),
    .fuse_threshold_in          (f_thr),
    .fuse_run_mode_in           (f_run),
    .fuse_sleep_mode_in         (f_slp),
    .fuse_rate_in               (f_rate),
    .unlock_key_in              (key),
    .deep_sleep_in              (sleep),
    .debug_halt_in              (dbg),
    .supply_below_bod_in        (bod_c),
    .supply_below_warn_in       (warn_c),
    .detector_ready_in          (rdy),
    .detector_power_out         (pwr),
    .threshold_select_out       (thr_o),
    .warning_level_select_out   (lvl_o),
    .sys_reset_req_out          (sysrst),
    .warning_irq_out            (irq),
    .continuous_hold_wakeup_out (hold)
  );

  sdm_supply_model sdm_supply_model_i (
    .core_clk_in       (clk),
    .power_in          (pwr),
    .below_bod_cmd_in  (bod_cmd),
    .below_warn_cmd_in (warn_cmd),
    .below_bod_out     (bod_c),
    .below_warn_out    (warn_c),
    .ready_out         (rdy)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  // Key pulse, then the sleep write in the very next cycle
  task automatic key_wr(input logic [7:0] d);
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    addr <= ADDR_MODE_CTRL;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  function automatic logic probe(input int w);
    case (w)
      0: return irq;
      1: return sysrst;
      3: return hold;
      default: return pwr;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic v, input int lim,
                          input string nm);
    int i;
    i = 0;
    while (probe(w) !== v && i < lim)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK(nm, v, probe(w))
    if (probe(w) !== v)
      close_out();
  endtask

  // Cycles from the end of one power window to the start of the next
  task automatic off_gap(input int e, input string nm);
    int k;
    k = 0;
    wait_for(2, 1'b0, 300, nm);
    while (pwr !== 1'b1 && k < 2100)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(nm, e, k)
    if (pwr !== 1'b1)
      close_out();
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cycles(6);
    rd_chk(ADDR_MODE_CTRL, 8'h16, "mode_ctrl");
    rd_chk(ADDR_THRESH, 8'h05, "thresh");
    `CHK("thr_out", 3'h5, thr_o)
    wr_reg(ADDR_MODE_CTRL, 8'h00);
    wr_reg(ADDR_THRESH, 8'h00);
    rd_chk(ADDR_MODE_CTRL, 8'h16, "mode_nokey");
    rd_chk(ADDR_THRESH, 8'h05, "thresh_ro");
    key_wr(8'h03);
    rd_chk(ADDR_MODE_CTRL, 8'h16, "sleep_rsvd");
    key_wr(8'h01);
    rd_chk(ADDR_MODE_CTRL, 8'h15, "sleep_key");
    // Key, then the write only after the window has run out
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    cycles(5);
    wr_reg(ADDR_MODE_CTRL, 8'h02);
    rd_chk(ADDR_MODE_CTRL, 8'h15, "sleep_late");
    rd_chk(8'h05, 8'h00, "unmapped");
    wr_reg(ADDR_WARN_LVL, 8'h01);
    `CHK("lvl_out", 2'h1, lvl_o)
    wr_reg(ADDR_IRQ_CTRL, 8'h01);
    cycles(10);
    `CHK("irq_idle", 1'b0, irq)
    warn_cmd <= 1'b1;
    wait_for(0, 1'b1, 20, "irq_fall");
    rd_chk(ADDR_STATUS, 8'h01, "status");
    rd_chk(ADDR_IRQ_FLAGS, 8'h01, "flag");
    @(posedge clk);
    dbg <= 1'b1;
    cycles(1);
    `CHK("irq_debug", 1'b0, irq)
    dbg <= 1'b0;
    wr_reg(ADDR_IRQ_FLAGS, 8'h00);
    `CHK("irq_w0", 1'b1, irq)
    wr_reg(ADDR_IRQ_FLAGS, 8'h01);
    `CHK("irq_w1c", 1'b0, irq)
    wr_reg(ADDR_IRQ_CTRL, 8'h03);
    warn_cmd <= 1'b0;
    wait_for(0, 1'b1, 20, "irq_rise");
    wr_reg(ADDR_IRQ_CTRL, 8'h04);
    wr_reg(ADDR_IRQ_FLAGS, 8'h01);
    wr_reg(ADDR_IRQ_CTRL, 8'h05);
    wait_for(0, 1'b1, 10, "irq_enable");
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(ADDR_IRQ_FLAGS, 8'h01);
      warn_cmd <= ~warn_cmd;
      wait_for(0, 1'b1, 20, "irq_both");
    end
    wr_reg(ADDR_IRQ_CTRL, 8'h01);
    wr_reg(ADDR_IRQ_FLAGS, 8'h01);
    bod_cmd <= 1'b1;
    wait_for(1, 1'b1, 20, "sysrst_on");
    bod_cmd <= 1'b0;
    wait_for(1, 1'b0, 20, "sysrst_off");
    key_wr(8'h00);
    sleep <= 1'b1;
    cycles(2);
    `CHK("pwr_sleep_off", 1'b0, pwr)
    warn_cmd <= 1'b1;
    bod_cmd <= 1'b1;
    cycles(20);
    `CHK("irq_det_off", 1'b0, irq)
    `CHK("rst_det_off", 1'b0, sysrst)
    warn_cmd <= 1'b0;
    bod_cmd <= 1'b0;
    cycles(5);
    sleep <= 1'b0;
    cycles(10);
    `CHK("pwr_wake", 1'b1, pwr)
    wr_reg(ADDR_IRQ_FLAGS, 8'h01);
    `CHK("irq_wake", 1'b0, irq)
    key_wr(8'h02);
    sleep <= 1'b1;
    cycles(10);
    n = 0;
    repeat (SLOW_SIM)
    begin
      @(posedge clk);
      #1;
      if (pwr === 1'b1)
        n++;
    end
    // Slow rate: one whole period holds exactly one power window
    `CHK("on_cycles", SAMPLE_ON_CYC, n)
    wait_for(2, 1'b1, 2100, "pwr_on");
    wait_for(2, 1'b0, 300, "pwr_off");
    off_gap(SLOW_SIM - SAMPLE_ON_CYC, "gap_slow");
    warn_cmd <= 1'b1;
    cycles(20);
    `CHK("irq_between", 1'b0, irq)
    wait_for(0, 1'b1, 2100, "irq_sample");
    // Second reset with new fuses, held asleep: fast sampled rate
    @(posedge clk);
    rst_n <= 1'b0;
    f_run <= 2'h3;
    f_rate <= 1'b0;
    warn_cmd <= 1'b0;
    cycles(5);
    `CHK("irq_reset", 1'b0, irq)
    @(posedge clk);
    rst_n <= 1'b1;
    cycles(6);
    rd_chk(ADDR_MODE_CTRL, 8'h0e, "mode_reload");
    off_gap(FAST_SIM - SAMPLE_ON_CYC, "gap_fast");
    // Wake while unpowered, so the detector is not yet running
    wait_for(2, 1'b0, 300, "pwr_off_hold");
    cycles(10);
    @(posedge clk);
    sleep <= 1'b0;
    cycles(1);
    `CHK("hold_set", 1'b1, hold)
    `CHK("pwr_wake_cont", 1'b1, pwr)
    wait_for(3, 1'b0, 20, "hold_clear");
    close_out();
  end
endmodule
